/* File: src/sld_pkg.sv */
// Purpose: shared constants for the shift-latch led sink driver and its controller
// Assumes: one system clock; the serial clock is a level from a divider, high for half its period
// Notes: word length and chain length live here
package sld_pkg;
    localparam int unsigned WORD_BITS = 8;
    localparam logic [7:0] SHIFT_RESET = 8'h00;
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam int unsigned CHAIN_LEN = 1;
    // serial clock period in system cycles (even, at least 2)
    localparam int unsigned SCLK_DIV = 4;
    localparam logic [3:0] SCLK_DIV_W = 4'h4;
    localparam logic [3:0] SCLK_HALF = 4'h2;
    localparam logic [3:0] BIT_CNT_MAX = 4'h8;
endpackage

/* File: src/sld_if.sv */
// Purpose: serial link between controller and led sink driver
// Assumes: all signals synchronous to clk_sys_i
// Notes: led sinks stay on the driver's own ports
`timescale 1ns/100ps
`default_nettype none
interface sld_if;
    logic serial_in;
    logic serial_clk;
    logic latch_strobe;
    logic output_gate_n;
    logic serial_out;
    modport dev (input serial_in, input serial_clk, input latch_strobe,
                 input output_gate_n, output serial_out);
    modport ctl (output serial_in, output serial_clk, output latch_strobe,
                 output output_gate_n, input serial_out);
endinterface
`default_nettype wire

/* File: src/sld_driver.sv */
// Purpose: eight-channel led sink driver with shift register and output latch
// Assumes: serial clock, strobe and gate sampled on clk_sys_i
// Notes: sinks are open drain: sink_oe high means the sink conducts;
//        the gate and the thermal cutoff act on the sink enables only, never
//        on the shift register or the output latch
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - rising serial clock shifts serial_in in
// - controller sends bit 7 first, bit 0 last
// - controller holds serial_in stable at edge
// - serial_out shows last stage on rising edge
// - serial_in reaches serial_out eight clocks later
// - drivers chain through serial_out to serial_in
// - strobe high makes latch follow shift register
// - strobe fall captures, low holds latch
// - gate high turns sinks off, latch kept
// - gate low makes sinks follow latch
// - shifting and latching ignore the gate
// - controller may pulse-width modulate the gate
// - over-temperature switches all sinks off
// - sinks return only after over-temperature clears
// - thermal events leave register and latch intact
module sld_driver (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    sld_if.dev link,
    input wire logic over_temp_i,
    output logic [7:0] led_sinks_o,
    output logic [7:0] led_sinks_oe_o,
    output logic [7:0] latch_o
);
    // ---------------------------------------------------------------
    // shared decode
    // ---------------------------------------------------------------

    // rising edge of a level that is sampled once per system clock
    function automatic logic sld_rise(
        input logic level_now,
        input logic level_before
    );
        return level_now & ~level_before;
    endfunction

    // one shift step: the new bit enters stage 0 and every stage moves up one
    function automatic logic [7:0] sld_shift_step(
        input logic [7:0] stages,
        input logic bit_in
    );
        return {stages[6:0], bit_in};
    endfunction

    // sinks conduct only where the latch holds a one and nothing blanks them
    function automatic logic [7:0] sld_sink_mask(
        input logic [7:0] latched,
        input logic blank
    );
        return blank ? 8'h00 : latched;
    endfunction

    // ---------------------------------------------------------------
    // serial clock edge detect
    // ---------------------------------------------------------------
    logic sclk_q, sclk_d;
    logic rise;

    // the serial clock is a plain level here; a rise is high now and low
    // one system cycle ago, so a long high phase gives a single shift
    always_comb begin
        sclk_d = link.serial_clk;
        rise = sld_rise(link.serial_clk, sclk_q);
    end

    // previous serial clock level; resets to the idle low level, no false rise
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sclk_q <= 1'b0;
        end else begin
            sclk_q <= sclk_d;
        end
    end

    // ---------------------------------------------------------------
    // shift register
    // ---------------------------------------------------------------
    logic [7:0] shift_q, shift_d;

    // each rise moves the word up one stage and takes serial_in at stage 0;
    // the gate and the thermal cutoff never reach this group
    always_comb begin
        shift_d = shift_q;
        if (rise) begin
            shift_d = sld_shift_step(shift_q, link.serial_in);
        end
    end

    // shift register flops
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            shift_q <= sld_pkg::SHIFT_RESET;
        end else begin
            shift_q <= shift_d;
        end
    end

    // ---------------------------------------------------------------
    // serial output stage
    // ---------------------------------------------------------------
    logic so_q, so_d;

    // the bit leaving stage 7 at a rise stands on serial_out until the next
    // rise, so a bit taken in shows up eight rises later and the next driver
    // of a chain samples it stably on its own rise
    always_comb begin
        so_d = so_q;
        if (rise) begin
            so_d = shift_q[7];
        end
    end

    // serial output flop
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            so_q <= 1'b0;
        end else begin
            so_q <= so_d;
        end
    end

    // ---------------------------------------------------------------
    // output latch
    // ---------------------------------------------------------------
    logic [7:0] latch_q, latch_d;

    // while the strobe is high the latch tracks the shift register one cycle
    // behind; the last value tracked before the strobe falls is the one kept,
    // so the strobe fall captures and a low strobe holds
    always_comb begin
        latch_d = latch_q; // low strobe holds the captured value
        if (link.latch_strobe) begin
            latch_d = shift_q;
        end
    end

    // output latch flops; the gate and the cutoff never write here
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            latch_q <= sld_pkg::LATCH_RESET;
        end else begin
            latch_q <= latch_d;
        end
    end

    // ---------------------------------------------------------------
    // thermal cutoff
    // ---------------------------------------------------------------
    logic hot_q, hot_d;

    // the sensor input carries its own hysteresis: it rises above the
    // shutdown point and falls only below the recovery point, so following
    // its level keeps the sinks off until the die has cooled; a user who
    // feeds a raw comparator here loses that hysteresis
    always_comb begin
        hot_d = over_temp_i;
    end

    // thermal flag flop; resets cool
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            hot_q <= 1'b0;
        end else begin
            hot_q <= hot_d;
        end
    end

    // ---------------------------------------------------------------
    // sink enables
    // ---------------------------------------------------------------
    logic [7:0] oe_q, oe_d;

    // latch bit n enables sink n; a high gate or a hot die blanks every sink
    // but leaves the latch alone, so the pattern comes back unchanged once
    // the gate drops or the die cools
    always_comb begin
        oe_d = sld_sink_mask(latch_q, link.output_gate_n || hot_q);
    end // enable bit n belongs to sink n

    // sink enable flops; all sinks off in reset
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            oe_q <= 8'h00;
        end else begin
            oe_q <= oe_d;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    // open drain sinks only ever pull low; the registered enables say which
    // sinks conduct, so the pins never glitch on a strobe or gate change
    assign link.serial_out = so_q;
    assign led_sinks_o = 8'h00; // open drain: drives low when enabled
    assign led_sinks_oe_o = oe_q;
    assign latch_o = latch_q;
endmodule
`default_nettype wire

/* File: src/sld_ctrl.sv */
// Purpose: controller that shifts words into a driver chain and strobes them
// Assumes: one word per driver, CHAIN_LEN drivers, first word to the far driver
// Notes: gate follows gate_n_i directly, for pwm dimming
`timescale 1ns/100ps
`default_nettype none
module sld_ctrl (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    sld_if.ctl link,
    input wire logic start_i,
    input wire logic [7:0] word_bits_i,
    input wire logic gate_n_i,
    output logic busy_o,
    output logic word_take_o,
    output logic echo_o
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SHIFT = 2'b01,
        ST_STROBE = 2'b10
    } sld_state_e;

    // ---------------------------------------------------------------
    // shift sequencer
    // ---------------------------------------------------------------
    sld_state_e st_q, st_d;
    logic [3:0] div_q, div_d;
    logic [3:0] bit_q, bit_d;
    logic [7:0] word_q, word_d;
    logic [7:0] words_q, words_d;
    logic sclk_q, sclk_d, sin_q, sin_d, le_q, le_d, gate_q, gate_d, take_q, take_d;
    logic echo_q, echo_d;
    logic busy_q, busy_d;

    // compare point for the rising serial clock, half a period into a bit
    function automatic logic [3:0] sld_sld_half();
        return sld_pkg::SCLK_HALF - 4'h1;
    endfunction

    // next sequencer state; words are sent msb first
    always_comb begin
        st_d = st_q;
        div_d = div_q;
        bit_d = bit_q;
        word_d = word_q;
        words_d = words_q;
        sclk_d = sclk_q;
        sin_d = sin_q;
        le_d = 1'b0;
        take_d = 1'b0;
        gate_d = gate_n_i;
        echo_d = echo_q;
        unique case (st_q)
            ST_IDLE: begin
                if (start_i) begin
                    word_d = word_bits_i;
                    take_d = 1'b1;
                    sin_d = word_bits_i[7];
                    bit_d = 4'h0;
                    div_d = 4'h0;
                    words_d = 8'h00;
                    st_d = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                div_d = div_q + 4'h1;
                if (div_q == sld_sld_half()) begin
                    sclk_d = 1'b1; // data stable a half period before
                end
                if (div_q == sld_pkg::SCLK_DIV_W - 4'h1) begin
                    div_d = 4'h0;
                    sclk_d = 1'b0;
                    echo_d = link.serial_out;
                    bit_d = bit_q + 4'h1;
                    word_d = {word_q[6:0], 1'b0};
                    sin_d = word_q[6];
                    if (bit_q == sld_pkg::BIT_CNT_MAX - 4'h1) begin
                        bit_d = 4'h0;
                        words_d = words_q + 8'h01;
                        if (words_q == 8'(sld_pkg::CHAIN_LEN - 1)) begin
                            st_d = ST_STROBE;
                        end else begin
                            word_d = word_bits_i;
                            sin_d = word_bits_i[7];
                            take_d = 1'b1;
                        end
                    end
                end
            end
            ST_STROBE: begin
                le_d = ~le_q;
                if (le_q) begin
                    st_d = ST_IDLE;
                end
            end
            default: st_d = ST_IDLE;
        endcase
        busy_d = (st_d != ST_IDLE); // registered so busy_o comes from a flop
    end

    // sequencer flops; gate idles high so the sinks stay off in reset
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_q <= ST_IDLE;
            div_q <= 4'h0;
            bit_q <= 4'h0;
            word_q <= 8'h00;
            words_q <= 8'h00;
            sclk_q <= 1'b0;
            sin_q <= 1'b0;
            le_q <= 1'b0;
            gate_q <= 1'b1;
            take_q <= 1'b0;
            echo_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            st_q <= st_d;
            div_q <= div_d;
            bit_q <= bit_d;
            word_q <= word_d;
            words_q <= words_d;
            sclk_q <= sclk_d;
            sin_q <= sin_d;
            le_q <= le_d;
            gate_q <= gate_d;
            take_q <= take_d;
            echo_q <= echo_d;
            busy_q <= busy_d;
        end
    end

    assign link.serial_in = sin_q;
    assign link.serial_clk = sclk_q;
    assign link.latch_strobe = le_q;
    assign link.output_gate_n = gate_q;
    assign busy_o = busy_q;
    assign word_take_o = take_q;
    assign echo_o = echo_q;
endmodule
`default_nettype wire

/* File: testbench/sld_link_checker.sv */
// Purpose: link checks between controller and led sink driver
// Assumes: one clock, async active low reset
// Notes: a shadow of the bits taken at each rise times serial_out
`timescale 1ns/100ps
`default_nettype none
module sld_link_checker (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic serial_in,
    input wire logic serial_clk,
    input wire logic latch_strobe,
    input wire logic output_gate_n,
    input wire logic serial_out
);
    localparam int FRAME = int'(sld_pkg::WORD_BITS * sld_pkg::CHAIN_LEN);
    logic sclk_q, sclk_d, rise;
    logic [7:0] shd_q, shd_d, cnt_q, cnt_d;
    // rise detect, bit shadow, rises since last strobe
    always_comb begin
        rise = serial_clk & ~sclk_q;
        sclk_d = serial_clk;
        shd_d = rise ? {shd_q[6:0], serial_in} : shd_q;
        cnt_d = latch_strobe ? 8'h00 : cnt_q + {7'h00, rise};
    end
    // helper registers
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sclk_q <= 1'b0;
            shd_q <= 8'h00;
            cnt_q <= 8'h00;
        end else begin
            sclk_q <= sclk_d;
            shd_q <= shd_d;
            cnt_q <= cnt_d;
        end
    end
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);
    sequence s_high_phase;
        ##1 serial_clk ##1 !serial_clk;
    endsequence
    property p_dout_delay; rise |=> serial_out == $past(shd_q[7]); endproperty
    a_dout_delay: assert property (p_dout_delay) else $error("serial_out delay wrong");
    property p_dout_hold; !rise |=> $stable(serial_out); endproperty
    a_dout_hold: assert property (p_dout_hold) else $error("serial_out moved");
    property p_din_hold; $rose(serial_clk) |-> $stable(serial_in) ##1 $stable(serial_in); endproperty
    a_din_hold: assert property (p_din_hold) else $error("serial_in moved");
    property p_sclk_shape; $rose(serial_clk) |-> s_high_phase; endproperty
    a_sclk_shape: assert property (p_sclk_shape) else $error("clock high phase");
    property p_quiet_strobe; serial_clk |-> !latch_strobe; endproperty
    a_quiet_strobe: assert property (p_quiet_strobe) else $error("strobe while clocking");
    property p_strobe_pulse; $rose(latch_strobe) |=> !latch_strobe; endproperty
    a_strobe_pulse: assert property (p_strobe_pulse) else $error("strobe too long");
    property p_word_len; $rose(latch_strobe) |-> cnt_q == 8'(FRAME); endproperty
    a_word_len: assert property (p_word_len) else $error("bit count wrong");
    property p_frame_end; ($fell(serial_clk) && cnt_q == 8'(FRAME)) |-> ##[0:8] latch_strobe;
    endproperty
    a_frame_end: assert property (p_frame_end) else $error("no strobe after frame");
endmodule
`default_nettype wire

/* File: testbench/shift_latch_led_sink_driver_tb.sv */
// Purpose: controller and driver back to back, user sides checked
// Assumes: CHAIN_LEN of one, so each word lands in the latch
// Notes: waits of three cycles cover the gate and heat lag
`timescale 1ns/100ps
`default_nettype none
module shift_latch_led_sink_driver_tb;
    logic clk_sys_i, nrst_i, start_i, gate_n_i, over_temp_i, busy_o, echo_o, word_take_o;
    logic [7:0] word_bits_i, led_sinks_o, led_sinks_oe_o, latch_o, last_w;
    logic [7:0] words [6] = '{8'hA5, 8'h5A, 8'h80, 8'h01, 8'hFF, 8'h00};
    int mismatches = 0, checks = 0, cycles = 0;
    sld_if link();
    sld_ctrl i_sld_ctrl (.clk_sys_i, .nrst_i, .link(link), .start_i, .word_bits_i,
        .gate_n_i, .busy_o, .word_take_o, .echo_o);
    sld_driver i_sld_driver (.clk_sys_i, .nrst_i, .link(link), .over_temp_i,
        .led_sinks_o, .led_sinks_oe_o, .latch_o);
    sld_link_checker i_sld_link_checker (.clk_sys_i, .nrst_i, .serial_in(link.serial_in),
        .serial_clk(link.serial_clk), .latch_strobe(link.latch_strobe),
        .output_gate_n(link.output_gate_n), .serial_out(link.serial_out));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        if (mismatches == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // gate and heat inputs, then let the sinks settle
    task automatic set_in(input logic g, input logic h);
        @(posedge clk_sys_i);
        gate_n_i <= g;
        over_temp_i <= h;
        repeat (3) @(posedge clk_sys_i);
        #1;
    endtask
    // shift one word through the controller and check the driver
    task automatic send(input logic [7:0] w);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        start_i <= 1'b1;
        word_bits_i <= w;
        @(posedge clk_sys_i);
        start_i <= 1'b0;
        #1;
        check({6'h00, busy_o, word_take_o}, 8'h03);
        repeat (20) @(posedge clk_sys_i);
        #1;
        check(latch_o, last_w);
        while (busy_o !== 1'b0 && n < 100) begin
            @(posedge clk_sys_i);
            #1;
            n++;
        end
        repeat (3) @(posedge clk_sys_i);
        #1;
        check(latch_o, w);
        check(led_sinks_oe_o, (gate_n_i | over_temp_i) ? 8'h00 : w);
        check({7'h00, echo_o}, {7'h00, last_w[0]});
        check(led_sinks_o, 8'h00);
        check({6'h00, busy_o, word_take_o}, 8'h00);
        last_w = w;
    endtask
    initial begin
        clk_sys_i = 1'b0;
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end
    // cut a hang short
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 2000) begin
            mismatches++;
            report_and_stop();
        end
    end
    initial begin
        nrst_i = 1'b0;
        start_i = 1'b0;
        word_bits_i = 8'h00;
        gate_n_i = 1'b1;
        over_temp_i = 1'b0;
        last_w = 8'h00;
        repeat (12) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        set_in(1'b0, 1'b0);
        foreach (words[i]) send(words[i]);
        set_in(1'b1, 1'b0);
        check(led_sinks_oe_o, 8'h00);
        send(8'h3C);
        set_in(1'b0, 1'b0);
        check(led_sinks_oe_o, 8'h3C);
        set_in(1'b0, 1'b1);
        check(led_sinks_oe_o, 8'h00);
        send(8'hC3);
        set_in(1'b0, 1'b0);
        check(led_sinks_oe_o, 8'hC3);
        report_and_stop();
    end
endmodule
`default_nettype wire
